// >>> rtl/isp_target_regs.svh
// Constants for the serial programming target: opcodes, memory sizes, timing.
// Assumes a 20 MHz core clock; included by bare name from rtl/.
`ifndef ISP_TARGET_REGS_SVH
`define ISP_TARGET_REGS_SVH

`define OP_EE_READ 8'hA0
`define OP_EE_WRITE 8'hC0
`define OP_FL_READ 8'h20
`define OP_FL_WRITE 8'h60
`define OP_HIGH_MASK 8'hF7
`define OP_LOCK_ERASE 8'hAC
`define LOCK_SUB_TOP 5'h1F
`define ERASE_NIBBLE 4'h8
`define BLANK_BYTE 8'hFF
`define POLL_MARK 8'hFF
`define EE_AW 6
`define FL_AW 7
`define EE_DEPTH 64
`define FL_DEPTH 128
`define CLK_HZ 20000000
`define WRITE_TIME_US 4000
`define ERASE_TIME_US 8000
`define WRITE_CYCLES (`WRITE_TIME_US * (`CLK_HZ / 1000000))
`define ERASE_CYCLES (`ERASE_TIME_US * (`CLK_HZ / 1000000))
`define TIMER_W 24

`endif

// >>> rtl/isp_target_pkg.sv
// Types shared by the serial programming target.
// Assumes the constants header is compiled alongside.
package isp_target_pkg;

  typedef enum logic [1:0] {er_idle, er_wait, er_done} erase_state_e;

endpackage : isp_target_pkg

// >>> rtl/sync3.sv
// Three-stage synchroniser for one pin; output moves once stages two and three agree.
// Assumes a single clock with synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module sync3 #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Pin in, clean level out
  input wire logic d,
  output logic q
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic q_r;

  // First stage feeds only the second, keeping metastability away from logic
  always_ff @(posedge core_clk) begin
    if (reset) begin
      s1_r <= RESET_VAL;
      s2_r <= RESET_VAL;
      s3_r <= RESET_VAL;
      q_r <= RESET_VAL;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        q_r <= s3_r;
      end
    end
  end

  assign q = q_r;

endmodule : sync3

`default_nettype wire

// >>> rtl/isp_target.sv
// Target side of a serial in-system programming port: EEPROM, small flash, lock bits, erase.
// Assumes the programmer is SPI mode 0 master, far slower than core_clk, and drives reset.
`timescale 1ns/1ps
`default_nettype none
`include "isp_target_regs.svh"

module isp_target #(
  parameter int unsigned WRITE_CYCLES = `WRITE_CYCLES,
  parameter int unsigned ERASE_CYCLES = `ERASE_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Programming pins
  input wire logic prog_reset_n,
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  // Status
  output logic prog_mode,
  output logic write_busy,
  output logic erase_busy,
  // Core memory port
  input wire logic [`EE_AW-1:0] core_ee_addr,
  input wire logic core_ee_we,
  input wire logic [7:0] core_ee_wdata,
  output logic [7:0] core_ee_rdata,
  input wire logic [`FL_AW-1:0] core_fl_addr,
  output logic [7:0] core_fl_rdata
);

  ////////////////////////////////////////////////////////////////////////////////
  logic rst_n_s;
  logic sck_s;
  logic mosi_s;
  logic prog_mode_r;
  logic sck_q_r;
  logic [2:0] bit_cnt_r;
  logic [1:0] byte_cnt_r;
  logic [7:0] rx_r;
  logic [7:0] tx_r;
  logic [7:0] b0_r;
  logic [7:0] b1_r;
  logic [7:0] b2_r;
  logic [7:0] ee_mem [`EE_DEPTH];
  logic [7:0] fl_mem [`FL_DEPTH];
  logic lock1_r;
  logic lock2_r;
  logic busy_r;
  logic busy_fl_r;
  logic [`FL_AW-1:0] busy_addr_r;
  logic [`TIMER_W-1:0] wcnt_r;
  logic [`TIMER_W-1:0] ecnt_r;
  isp_target_pkg::erase_state_e er_state_r;
  logic erase_busy_r;
  logic [7:0] core_ee_rdata_r;
  logic [7:0] core_fl_rdata_r;

  sync3 #(.RESET_VAL(1'b1)) u_sync_rst (.core_clk(core_clk), .reset(reset),
    .d(prog_reset_n), .q(rst_n_s));
  sync3 #(.RESET_VAL(1'b0)) u_sync_sck (.core_clk(core_clk), .reset(reset),
    .d(sck), .q(sck_s));
  sync3 #(.RESET_VAL(1'b0)) u_sync_mosi (.core_clk(core_clk), .reset(reset),
    .d(mosi), .q(mosi_s));

  ////////////////////////////////////////////////////////////////////////////////
  logic sck_rise;
  logic sck_fall;
  logic [7:0] rx_nxt;
  logic byte_done;
  logic frame_end;
  logic write_locked;
  logic read_locked;
  logic is_ee_rd;
  logic is_fl_rd;
  logic [`FL_AW-1:0] fl_idx;
  logic [7:0] ee_rd;
  logic [7:0] fl_rd;
  logic [7:0] tx_nxt;
  logic ee_we_isp;
  logic fl_we_isp;
  logic erase_cmd;
  logic erase_do;
  logic unlocked;

  assign sck_rise = prog_mode_r & sck_s & ~sck_q_r;
  assign sck_fall = prog_mode_r & ~sck_s & sck_q_r;
  assign rx_nxt = {rx_r[6:0], mosi_s};
  assign byte_done = sck_rise & (bit_cnt_r == 3'h7);
  assign frame_end = byte_done & (byte_cnt_r == 2'h3);
  assign write_locked = ~lock1_r;
  assign read_locked = ~lock1_r & ~lock2_r;
  assign unlocked = lock1_r & lock2_r;
  assign is_ee_rd = (b0_r == `OP_EE_READ);
  assign is_fl_rd = ((b0_r & `OP_HIGH_MASK) == `OP_FL_READ);
  assign fl_idx = {rx_nxt[`FL_AW-2:0], b0_r[3]};

  // Location still being programmed answers the marker
  always_comb begin
    ee_rd = ee_mem[rx_nxt[`EE_AW-1:0]];
    if (busy_r && !busy_fl_r && busy_addr_r[`EE_AW-1:0] == rx_nxt[`EE_AW-1:0]) begin
      ee_rd = `POLL_MARK;
    end
    fl_rd = fl_mem[fl_idx];
    if (busy_r && busy_fl_r && busy_addr_r == fl_idx) begin
      fl_rd = `POLL_MARK;
    end
  end

  // Byte four of a read carries data unless reads are locked; otherwise the last byte received goes back out
  always_comb begin
    tx_nxt = rx_nxt;
    if (byte_cnt_r == 2'h2 && !read_locked) begin
      if (is_ee_rd) begin
        tx_nxt = ee_rd;
      end else if (is_fl_rd) begin
        tx_nxt = fl_rd;
      end
    end
  end

  // Writes are refused while locked or while an erase is pending
  assign ee_we_isp = frame_end & (b0_r == `OP_EE_WRITE) & ~write_locked
    & (er_state_r == isp_target_pkg::er_idle);
  assign fl_we_isp = frame_end & ((b0_r & `OP_HIGH_MASK) == `OP_FL_WRITE) & ~write_locked
    & (er_state_r == isp_target_pkg::er_idle);
  assign erase_cmd = frame_end & (b0_r == `OP_LOCK_ERASE) & (b1_r[7:4] == `ERASE_NIBBLE);
  assign erase_do = (er_state_r == isp_target_pkg::er_wait) & prog_mode_r & (ecnt_r == '0);

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (reset) begin
      prog_mode_r <= 1'b0;
      sck_q_r <= 1'b0;
    end else begin
      prog_mode_r <= ~rst_n_s;
      sck_q_r <= sck_s;
    end
  end

  // Mode 0 shifter; the frame is dropped whenever reset is let go
  always_ff @(posedge core_clk) begin
    if (reset || !prog_mode_r) begin
      bit_cnt_r <= 3'h0;
      byte_cnt_r <= 2'h0;
      rx_r <= 8'h00;
      tx_r <= 8'h00;
      b0_r <= 8'h00;
      b1_r <= 8'h00;
      b2_r <= 8'h00;
    end else if (sck_rise) begin
      rx_r <= rx_nxt;
      bit_cnt_r <= bit_cnt_r + 3'h1;
      if (bit_cnt_r == 3'h7) begin
        byte_cnt_r <= byte_cnt_r + 2'h1;
        tx_r <= tx_nxt;
        unique case (byte_cnt_r)
          2'h0: b0_r <= rx_nxt;
          2'h1: b1_r <= rx_nxt;
          2'h2: b2_r <= rx_nxt;
          2'h3: b0_r <= b0_r;
        endcase
      end
    end else if (sck_fall && bit_cnt_r != 3'h0) begin
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end

  // Non-volatile arrays keep contents across reset
  always_ff @(posedge core_clk) begin
    if (erase_do) begin
      for (int i = 0; i < `EE_DEPTH; i++) begin
        ee_mem[i] <= `BLANK_BYTE;
      end
      for (int i = 0; i < `FL_DEPTH; i++) begin
        fl_mem[i] <= `BLANK_BYTE;
      end
    end else begin
      if (ee_we_isp) begin
        ee_mem[b2_r[`EE_AW-1:0]] <= rx_nxt;
      end else if (core_ee_we) begin
        ee_mem[core_ee_addr] <= core_ee_wdata;
      end
      if (fl_we_isp) begin
        fl_mem[{b2_r[`FL_AW-2:0], b0_r[3]}] <= fl_mem[{b2_r[`FL_AW-2:0], b0_r[3]}] & rx_nxt;
      end
    end
  end

  // Core reads never look at the lock bits
  always_ff @(posedge core_clk) begin
    if (reset) begin
      core_ee_rdata_r <= 8'h00;
      core_fl_rdata_r <= 8'h00;
    end else begin
      core_ee_rdata_r <= ee_mem[core_ee_addr];
      core_fl_rdata_r <= fl_mem[core_fl_addr];
    end
  end

  // Write cycle timer; a second write restarts it at the new location
  always_ff @(posedge core_clk) begin
    if (reset) begin
      busy_r <= 1'b0;
      busy_fl_r <= 1'b0;
      busy_addr_r <= '0;
      wcnt_r <= '0;
    end else if (ee_we_isp || fl_we_isp) begin
      busy_r <= 1'b1;
      busy_fl_r <= fl_we_isp;
      busy_addr_r <= fl_we_isp ? {b2_r[`FL_AW-2:0], b0_r[3]} : {1'b0, b2_r[`EE_AW-1:0]};
      wcnt_r <= `TIMER_W'(WRITE_CYCLES - 1);
    end else if (busy_r) begin
      if (wcnt_r == '0) begin
        busy_r <= 1'b0;
      end else begin
        wcnt_r <= wcnt_r - `TIMER_W'(1);
      end
    end
  end

  // Lock bits: writing zero enables; only a finished erase or core reset brings them back
  always_ff @(posedge core_clk) begin
    if (reset) begin
      lock1_r <= 1'b1;
      lock2_r <= 1'b1;
    end else if (er_state_r == isp_target_pkg::er_done && !prog_mode_r) begin
      lock1_r <= 1'b1;
      lock2_r <= 1'b1;
    end else if (frame_end && b0_r == `OP_LOCK_ERASE && b1_r[7:3] == `LOCK_SUB_TOP
                 && b1_r[0]) begin
      lock1_r <= lock1_r & b1_r[1];
      lock2_r <= lock2_r & b1_r[2];
    end
  end

  // Erase runs while reset is held; releasing early abandons it with locks intact
  always_ff @(posedge core_clk) begin
    if (reset) begin
      er_state_r <= isp_target_pkg::er_idle;
      ecnt_r <= '0;
      erase_busy_r <= 1'b0;
    end else begin
      unique case (er_state_r)
        isp_target_pkg::er_idle: begin
          if (erase_cmd) begin
            er_state_r <= isp_target_pkg::er_wait;
            ecnt_r <= `TIMER_W'(ERASE_CYCLES - 1);
            erase_busy_r <= 1'b1;
          end
        end
        isp_target_pkg::er_wait: begin
          if (!prog_mode_r) begin
            er_state_r <= isp_target_pkg::er_idle;
            erase_busy_r <= 1'b0;
          end else if (ecnt_r == '0) begin
            er_state_r <= isp_target_pkg::er_done;
          end else begin
            ecnt_r <= ecnt_r - `TIMER_W'(1);
          end
        end
        isp_target_pkg::er_done: begin
          if (!prog_mode_r) begin
            er_state_r <= isp_target_pkg::er_idle;
            erase_busy_r <= 1'b0;
          end
        end
      endcase
    end
  end

  assign miso = tx_r[7];
  assign prog_mode = prog_mode_r;
  assign write_busy = busy_r;
  assign erase_busy = erase_busy_r;
  assign core_ee_rdata = core_ee_rdata_r;
  assign core_fl_rdata = core_fl_rdata_r;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_echo_prev_byte: assert property (byte_done && byte_cnt_r != 2'h2 |=> tx_r == $past(rx_nxt))
    else $error("echoed byte differs from previous byte");
  a_locked_read_echo: assert property (byte_done && byte_cnt_r == 2'h2 && read_locked
    |=> tx_r == $past(rx_nxt))
    else $error("locked read did not echo low address");
  a_ee_read_data: assert property (byte_done && byte_cnt_r == 2'h2 && is_ee_rd && !read_locked
    |=> tx_r == $past(ee_rd))
    else $error("EEPROM read returned wrong byte");
  a_poll_marker: assert property (byte_done && byte_cnt_r == 2'h2 && is_ee_rd && !read_locked
    && busy_r && !busy_fl_r && busy_addr_r[`EE_AW-1:0] == rx_nxt[`EE_AW-1:0]
    |=> tx_r == `POLL_MARK)
    else $error("busy location did not read marker");
  a_ee_write_store: assert property (ee_we_isp
    |=> busy_r && ee_mem[busy_addr_r[`EE_AW-1:0]] == $past(rx_nxt) ##1 busy_r [*4])
    else $error("EEPROM write not stored or cycle too short");
  a_write_refused: assert property (frame_end && b0_r == `OP_EE_WRITE && write_locked && !busy_r
    |=> !busy_r)
    else $error("write accepted while locked");
  // Compare against the old contents of the written byte, not the frame's read path
  a_flash_no_set: assert property (fl_we_isp
    |=> (fl_mem[busy_addr_r] & ~$past(fl_mem[{b2_r[`FL_AW-2:0], b0_r[3]}])) == 8'h00)
    else $error("flash bit went from zero to one");
  a_erase_blank: assert property (erase_do
    |=> ee_mem[0] == `BLANK_BYTE && fl_mem[`FL_DEPTH-1] == `BLANK_BYTE)
    else $error("erase left non-blank data");
  a_unlock_after_erase: assert property ($rose(unlocked)
    |-> $past(erase_busy_r) && !$past(prog_mode_r))
    else $error("locks cleared without finished erase");
  a_core_write: assert property (core_ee_we && !ee_we_isp && !erase_do
    |=> ee_mem[$past(core_ee_addr)] == $past(core_ee_wdata))
    else $error("core write lost");

  c_ee_write: cover property (ee_we_isp);
  c_locked_read: cover property (byte_done && byte_cnt_r == 2'h2 && read_locked);
  c_erase_end: cover property (er_state_r == isp_target_pkg::er_done && !prog_mode_r);
  c_lock_prog: cover property ($fell(lock1_r));

endmodule : isp_target

`default_nettype wire

// >>> verif/isp_programmer.sv
// Behavioural model of the external programmer: a mode 0 link master and the reset pin.
// Assumes the target samples sck and mosi with its own core clock through synchronisers.
`timescale 1ns/1ps
`default_nettype none

module isp_programmer (
  // Core clock, used to time the reset pin and the start of each frame
  input wire logic core_clk,
  // Link pins
  output logic prog_reset_n,
  output logic sck,
  output logic mosi,
  input wire logic miso
);
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    prog_reset_n = 1'b1;
    sck = 1'b0;
    mosi = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Four bytes, MSB first; sck idles low between frames
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    @(posedge core_clk);
    #7;
    for (int i = 31; i >= 0; i--) begin
      mosi = tx[i];
      #200 sck = 1'b1;
      // Sampled late in the high phase: miso moves after the synced fall, or after the synced rise at a byte end
      #190 rx[i] = miso;
      #10 sck = 1'b0;
    end
    // Released line shows no stale value
    mosi = ~tx[0];
    #400;
  endtask : xfer

  task automatic hold_reset(input logic v);
    @(posedge core_clk);
    prog_reset_n <= v;
  endtask : hold_reset

  // Short release that ends an erase cycle, then back into programming mode
  task automatic pulse_reset;
    @(posedge core_clk);
    prog_reset_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    prog_reset_n <= 1'b0;
  endtask : pulse_reset
endmodule : isp_programmer

`default_nettype wire

// >>> verif/serial_prog_eeprom_lock_erase_tb.sv
// Self-checking bench for the serial programming target.
// Assumes the design header and the programmer model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "isp_target_regs.svh"

module serial_prog_eeprom_lock_erase_tb;
  localparam int WR_CYC = 600;
  localparam int ER_CYC = 400;
  typedef struct packed {logic [31:0] frame; logic [7:0] data;} row_s;

  logic core_clk, reset, prog_reset_n, sck, mosi, miso;
  logic prog_mode, write_busy, erase_busy, core_ee_we;
  logic [`EE_AW-1:0] core_ee_addr;
  logic [7:0] core_ee_wdata, core_ee_rdata, core_fl_rdata;
  logic [`FL_AW-1:0] core_fl_addr;
  int failures = 0;
  int compares = 0;
  row_s rows [9];

  ////////////////////////////////////////////////////////////////////////////////
  isp_target #(.WRITE_CYCLES(WR_CYC), .ERASE_CYCLES(ER_CYC)) isp_target_inst (
    .core_clk(core_clk), .reset(reset), .prog_reset_n(prog_reset_n), .sck(sck),
    .mosi(mosi), .miso(miso), .prog_mode(prog_mode), .write_busy(write_busy),
    .erase_busy(erase_busy), .core_ee_addr(core_ee_addr), .core_ee_we(core_ee_we),
    .core_ee_wdata(core_ee_wdata), .core_ee_rdata(core_ee_rdata),
    .core_fl_addr(core_fl_addr), .core_fl_rdata(core_fl_rdata));

  isp_programmer isp_programmer_inst (.core_clk(core_clk), .prog_reset_n(prog_reset_n),
    .sck(sck), .mosi(mosi), .miso(miso));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic run(input logic [31:0] f, input logic [7:0] d);
    logic [31:0] r;
    isp_programmer_inst.xfer(f, r);
    chk(r[23:0], {f[31:16], d}, "frame answer");
  endtask : run

  // Bounded waits so a stuck flag ends as a mismatch, not a hang
  task automatic wait_idle;
    int n;
    n = 0;
    while (write_busy !== 1'b0 && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    chk(write_busy, 1'b0, "write cycle end");
  endtask : wait_idle

  task automatic wait_mode;
    int n;
    n = 0;
    while (prog_mode !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    chk(prog_mode, 1'b1, "programming mode");
    repeat (12) @(posedge core_clk);
  endtask : wait_mode

  task automatic core_wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk);
    core_ee_addr <= a;
    core_ee_wdata <= d;
    core_ee_we <= 1'b1;
    @(posedge core_clk);
    core_ee_we <= 1'b0;
  endtask : core_wr

  task automatic core_rd(input logic [5:0] a, input logic [6:0] f, input logic [15:0] exp);
    @(posedge core_clk);
    core_ee_addr <= a;
    core_fl_addr <= f;
    repeat (2) @(posedge core_clk);
    #1;
    chk({core_ee_rdata, core_fl_rdata}, exp, "core read");
  endtask : core_rd

  task automatic erase_start;
    run(32'hAC800000, 8'h00);
    chk(erase_busy, 1'b1, "erase pending");
    repeat (ER_CYC + 50) @(posedge core_clk);
  endtask : erase_start

  task automatic erase_end;
    isp_programmer_inst.pulse_reset();
    wait_mode();
    chk(erase_busy, 1'b0, "erase ended");
  endtask : erase_end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge core_clk);
    failures++;
    $display("BAD t=%0t watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    reset <= 1'b1;
    core_ee_we <= 1'b0;
    core_ee_addr <= 6'h00;
    core_ee_wdata <= 8'h00;
    core_fl_addr <= 7'h00;
    rows = '{'{32'hA0003F00, 8'hFF}, '{32'h20000500, 8'hFF}, '{32'hC000110F, 8'h11},
             '{32'hA0001100, 8'h0F}, '{32'hC0003FAB, 8'h3F}, '{32'hA0003F00, 8'hAB},
             '{32'h600005F0, 8'h05}, '{32'h6000050F, 8'h05}, '{32'h20000500, 8'h00}};
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    #1;
    chk({prog_mode, write_busy, erase_busy, miso}, 4'h0, "reset outputs");
    chk({core_ee_rdata, core_fl_rdata}, 16'h0000, "reset read data");
    isp_programmer_inst.hold_reset(1'b0);
    wait_mode();
    // Memories power up unknown, so erase before anything else
    erase_start();
    erase_end();
    foreach (rows[i]) begin
      run(rows[i].frame, rows[i].data);
      wait_idle();
    end
    // Polling: busy location shows the marker, then the new value
    run(32'hC0002055, 8'h20);
    run(32'hA0002000, 8'hFF);
    wait_idle();
    run(32'hA0002000, 8'h55);
    core_wr(6'h03, 8'h5A);
    run(32'hA0000300, 8'h5A);
    // Write lock first, then read lock
    run(32'hACFD0000, 8'h00);
    repeat (WR_CYC) @(posedge core_clk);
    run(32'hC0001177, 8'h11);
    wait_idle();
    run(32'hA0001100, 8'h0F);
    run(32'h60000700, 8'h07);
    wait_idle();
    run(32'h20000700, 8'hFF);
    run(32'hACFB0000, 8'h00);
    repeat (WR_CYC) @(posedge core_clk);
    run(32'hA0001100, 8'h11);
    run(32'h20000500, 8'h05);
    core_rd(6'h11, 7'h0A, 16'h0F00);
    // Locks stay in force until the erase cycle is closed
    erase_start();
    run(32'hA0001100, 8'h11);
    erase_end();
    run(32'hA0001100, 8'hFF);
    core_rd(6'h11, 7'h0A, 16'hFFFF);
    run(32'hACFB0000, 8'h00);
    repeat (WR_CYC) @(posedge core_clk);
    run(32'hC0001233, 8'h12);
    wait_idle();
    run(32'hA0001200, 8'h33);
    report_and_stop();
  end
endmodule : serial_prog_eeprom_lock_erase_tb

`default_nettype wire
